// file: common/conv_port_pkg.sv
// Purpose: constants for the converter bus port
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   times are kept in ns, cycle counts derived from them
package conv_port_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 5;
    // result valid within this long of a start
    localparam int unsigned CONV_TIME_NS   = 10000;
    // longest conversion, rounded down to whole cycles
    localparam int unsigned CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;
    // least low time of all three controls before a start is taken
    localparam int unsigned START_LOW_NS   = 300;
    localparam int unsigned START_CYCLES   =
        (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned CODE_BIT       = 0;   // coding-format data bit
    localparam int unsigned POL_BIT        = 1;   // polarity data bit
    localparam logic [7:0]  RESULT_RESET   = 8'h00;
    localparam logic [7:0]  MSB_FLIP       = 8'h80;
    localparam logic [7:0]  HALF_SCALE     = 8'h80;
    // format settings
    localparam logic [1:0]  FMT_UNI_BIN    = 2'h0;
    localparam logic [1:0]  FMT_BIP_OFS    = 2'h1;
    localparam logic [1:0]  FMT_UNI_TWOS   = 2'h2;
    localparam logic [1:0]  FMT_BIP_TWOS   = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } conv_state_e;
endpackage

// file: rtl/conv_bus_port.sv
// Purpose: bus side of a self-timed 8-bit converter: start, result, format
// Assumes: control inputs synchronous to clk_sys_in; analog code arrives
//          already sampled on sample_code_in
// Notes:   tri-state data shown as data, enable pair
`timescale 1ns/1ps
module conv_bus_port #(
    parameter int unsigned CONV_CYC  = conv_port_pkg::CONV_CYCLES,
    parameter int unsigned START_CYC = conv_port_pkg::START_CYCLES
) (
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    input  wire logic       chip_sel_n_in,
    input  wire logic       chip_en_n_in,
    input  wire logic       host_addr_bit0_in,
    input  wire logic [7:0] data_in,
    input  wire logic [7:0] sample_code_in,
    output logic      [7:0] data_out,
    output logic            data_oe_out,
    output logic            busy_out,
    output logic            coding_format_out,
    output logic            polarity_select_out
);
    // ****************************************
    // decode
    // ****************************************
    conv_port_pkg::conv_state_e state;
    logic [15:0] low_cnt;
    logic [15:0] conv_cnt;
    logic        fired;
    logic [1:0]  fmt;

    // all three low completes a start, whichever fell last
    wire ctl_low   = !chip_sel_n_in && !chip_en_n_in;
    wire start_req = ctl_low && !host_addr_bit0_in;
    wire read_req  = ctl_low && host_addr_bit0_in;
    wire start_ok  = start_req && !fired &&
                     (low_cnt == 16'(START_CYC - 1));
    wire conv_end  = conv_cnt == 16'(CONV_CYC - 1);
    wire busy_now  = state == conv_port_pkg::ST_CONV;

    // coding per two-bit setting
    wire [7:0] raw_bin  = sample_code_in;
    wire [7:0] coded    =
        (fmt == conv_port_pkg::FMT_UNI_BIN)  ? raw_bin :
        (fmt == conv_port_pkg::FMT_BIP_OFS)  ? raw_bin :
        (fmt == conv_port_pkg::FMT_UNI_TWOS) ?
            raw_bin - conv_port_pkg::HALF_SCALE :
            raw_bin ^ conv_port_pkg::MSB_FLIP;
    logic [7:0] result;

    // ****************************************
    // start qualifier
    // ****************************************
    // count low time; one start per low period
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !start_req) begin
            low_cnt <= 16'h0000;
            fired   <= 1'b0;
        end else begin
            if (low_cnt != 16'(START_CYC - 1)) low_cnt <= low_cnt + 16'h0001;
            if (start_ok) fired <= 1'b1;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    // idle, converting, result held
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state    <= conv_port_pkg::ST_IDLE;
            conv_cnt <= 16'h0000;
            fmt      <= conv_port_pkg::FMT_UNI_BIN;
            result   <= conv_port_pkg::RESULT_RESET;
        end else begin
            unique case (state)
                conv_port_pkg::ST_IDLE, conv_port_pkg::ST_DONE: begin
                    if (start_ok) begin
                        // low two bits only
                        fmt      <= {data_in[conv_port_pkg::POL_BIT],
                                     data_in[conv_port_pkg::CODE_BIT]};
                        conv_cnt <= 16'h0000;
                        state    <= conv_port_pkg::ST_CONV;
                    end
                end
                conv_port_pkg::ST_CONV: begin
                    // starts ignored here bounded time
                    conv_cnt <= conv_cnt + 16'h0001;
                    if (conv_end) begin
                        result <= coded;
                        state  <= conv_port_pkg::ST_DONE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // drive only on read, never while busy
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            data_out            <= conv_port_pkg::RESULT_RESET;
            data_oe_out         <= 1'b0;
            busy_out            <= 1'b0;
            coding_format_out   <= 1'b0;
            polarity_select_out <= 1'b0;
        end else begin
            data_out            <= result;
            data_oe_out         <= read_req && !busy_now && !start_ok;
            busy_out            <= busy_now || start_ok;
            coding_format_out   <= fmt[conv_port_pkg::CODE_BIT];
            // polarity pin follows data bit 1 of the start write
            polarity_select_out <= fmt[conv_port_pkg::POL_BIT];
        end
    end
endmodule

// file: verification/adc_host_bus_glue_bench.sv
// Purpose: self-checking bench for the converter port
// Assumes: short counts, conversion 20 cycles
// Notes:   all four format settings are run
`timescale 1ns/1ps
module adc_host_bus_glue_bench;
    logic clk_sys_in = 0, resetn_in = 0, sel_n, en_n, a0, oe, busy, cf, pol;
    logic [7:0] raw = 8'h00, q, exp, wd, dout;
    bit ok;
    int num_errors = 0, checks_done = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    // outside sample/hold: track while idle, hold while busy
    wire track = !busy;
    conv_bus_port #(.CONV_CYC(20), .START_CYC(2)) uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .chip_sel_n_in(sel_n), .chip_en_n_in(en_n), .host_addr_bit0_in(a0), .data_in(wd), .sample_code_in(raw),
        .data_out(dout), .data_oe_out(oe), .busy_out(busy), .coding_format_out(cf), .polarity_select_out(pol));
    host_bus_model host (.clk_sys_in(clk_sys_in), .data_oe_in(oe), .data_res_in(dout),
        .sel_n_out(sel_n), .en_n_out(en_n), .addr0_out(a0), .data_out(wd));
    task automatic check(input logic [7:0] got, want);
        checks_done++;
        if (got !== want) begin num_errors++; $display("CHECK FAILED %0t got %h want %h", $time, got, want); end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // four settings, each with an ignored second start
    initial begin
        repeat (5) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            raw <= 8'h37 + 8'h50 * f[7:0];
            host.start({6'h2a, f[1:0]}, f[0]);
            #1 check({7'h0, busy}, 8'h01);
            check({7'h0, track}, 8'h00);
            host.set_channel(8'hfc | f[7:0]);
            #1 check({6'h0, host.chan_sel}, {6'h0, f[1:0]});
            host.start({6'h15, ~f[1:0]}, 1'b0);
            for (int i = 0; i < 30 && busy !== 1'b0; i++) begin @(posedge clk_sys_in); #1; end
            check({7'h0, busy}, 8'h00);
            check({6'h0, pol, cf}, {6'h0, f[1], f[0]});
            exp = (f > 1) ? raw ^ 8'h80 : raw;
            host.read(q, ok);
            if (!ok) begin num_errors++; finish_test(); end
            check(q, exp);
            @(posedge clk_sys_in); #1 check({7'h0, oe}, 8'h00);
            $display("test format %0d done", f);
        end
        finish_test();
    end
endmodule
bind conv_bus_port conv_bus_port_sva chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .chip_sel_n_in(chip_sel_n_in), .chip_en_n_in(chip_en_n_in), .host_addr_bit0_in(host_addr_bit0_in),
    .data_oe_out(data_oe_out), .busy_out(busy_out), .coding_format_out(coding_format_out),
    .polarity_select_out(polarity_select_out));

// file: verification/conv_bus_port_sva.sv
// Purpose: timing checks on the converter bus port
// Assumes: one clock, sync active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module conv_bus_port_sva (
    input wire logic clk_sys_in, resetn_in, chip_sel_n_in, chip_en_n_in,
    input wire logic host_addr_bit0_in, data_oe_out, busy_out,
    input wire logic coding_format_out, polarity_select_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // both controls low
    wire sel_on = !chip_sel_n_in && !chip_en_n_in;
    sequence rd_held;
        sel_on && host_addr_bit0_in && !busy_out ##1 sel_on && host_addr_bit0_in;
    endsequence
    chk_take_cause: assert property ($rose(busy_out) |-> $past(sel_on && !host_addr_bit0_in)) else $error("busy without start");
    chk_busy_len: assert property ($rose(busy_out) |-> busy_out[*8] ##[1:1000] !busy_out) else $error("busy length");
    chk_no_retake: assert property ($fell(busy_out) |=> !busy_out) else $error("restart");
    chk_oe_idle: assert property (busy_out |-> !data_oe_out) else $error("oe while busy");
    chk_oe_cause: assert property (data_oe_out |-> $past(sel_on && host_addr_bit0_in)) else $error("oe no read");
    chk_oe_drop: assert property ($rose(chip_en_n_in) |=> !data_oe_out) else $error("oe held");
    chk_read_on: assert property (rd_held |-> data_oe_out) else $error("oe missing");
    chk_fmt_hold: assert property ($changed({coding_format_out, polarity_select_out}) |-> $past(busy_out) && !$past(busy_out, 2)) else $error("fmt moved");
endmodule

// file: verification/host_bus_model.sv
// Purpose: host side of the converter port
// Assumes: decode, dma gating and strobe merge already done
// Notes:   released data shows the inverse of the last start write
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       clk_sys_in,
    input  wire logic       data_oe_in,
    input  wire logic [7:0] data_res_in,
    output logic            sel_n_out,
    output logic            en_n_out,
    output logic            addr0_out,
    output logic [7:0]      data_out
);
    logic [1:0] chan_sel = 2'h0;
    initial begin sel_n_out = 1; en_n_out = 1; addr0_out = 1; data_out = 8'ha5; end
    // write to the mux address: latch the two low data bits
    task automatic set_channel(input logic [7:0] d);
        @(posedge clk_sys_in);
        chan_sel <= d[1:0];
    endtask
    // start at even address, optional late strobe
    task automatic start(input logic [7:0] d, input logic stag);
        @(posedge clk_sys_in);
        sel_n_out <= 1'b0; addr0_out <= 1'b0; en_n_out <= stag; data_out <= d;
        if (stag) begin @(posedge clk_sys_in); en_n_out <= 1'b0; end
        repeat (4) @(posedge clk_sys_in);
        sel_n_out <= 1'b1; en_n_out <= 1'b1; data_out <= ~d;
    endtask
    // read at odd address, bounded wait for enable
    task automatic read(output logic [7:0] q, output bit ok);
        ok = 0;
        @(posedge clk_sys_in);
        sel_n_out <= 1'b0; en_n_out <= 1'b0; addr0_out <= 1'b1;
        for (int i = 0; i < 8 && !ok; i++) begin @(posedge clk_sys_in); #1 ok = data_oe_in === 1'b1; end
        q = data_res_in;
        @(posedge clk_sys_in);
        sel_n_out <= 1'b1; en_n_out <= 1'b1;
    endtask
endmodule
